// file: src/irrt_map.svh
// Register indices, reset values, field positions and timing figures of the block.
`ifndef IRRT_MAP_SVH
`define IRRT_MAP_SVH

`define IRRT_IDX_IR_BASE 8'h2B
`define IRRT_IDX_DMA_SEL 8'h2C
`define IRRT_IDX_HD_TIMEOUT 8'h2D
`define IRRT_IDX_SW_SEL_A 8'h2E
`define IRRT_IDX_SW_SEL_B 8'h2F
`define IRRT_IDX_RT_BASE 8'h30

`define IRRT_RST_IR_BASE 8'h00
`define IRRT_RST_DMA_SEL 4'hF
`define IRRT_RST_HD_TIMEOUT 8'h03
`define IRRT_RST_SW_SEL 8'h00
`define IRRT_RST_RT_BASE 7'h00

`define IRRT_DMA_NONE 4'hF
`define IRRT_DMA_LAST 4'h3
`define IRRT_DMA_FIELD 3:0
`define IRRT_DMA_RSVD_ZERO 4'h0
`define IRRT_RT_BASE_FIELD 7:1
`define IRRT_RT_RSVD_ZERO 1'b0

`define IRRT_IR_TOP_FIELD 15:11
`define IRRT_IR_BASE_FIELD 10:3
`define IRRT_IR_ENABLE_FIELD 7:5
`define IRRT_RT_TOP_FIELD 15:12
`define IRRT_RT_BASE_ADDR_FIELD 11:5
`define IRRT_RT_ENABLE_FIELD 6:3
`define IRRT_RT_OFS_FIELD 4:0
`define IRRT_RT_OFS_WAKE_STS 5'h00

`define IRRT_CLK_PERIOD_PS 5000
`define IRRT_TICK_US 100
`define IRRT_PS_PER_US 1000000

`endif

// file: src/irrt_pkg.sv
// Types shared by the configuration register block and its address decoder.
package irrt_pkg;

  typedef struct packed {
    logic in_cfg_state;
    logic [7:0] index;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } irrt_cfg_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } irrt_io_req_t;

  typedef struct packed {
    logic ir_hit;
    logic rt_hit;
    logic rt_wake_sts;
    logic [4:0] rt_offset;
  } irrt_dec_t;

endpackage

// file: src/irrt_addr_decode.sv
// Address decoder for the fast infrared engine window and the runtime block window.
`timescale 1ns/1ps
`include "irrt_map.svh"
module irrt_addr_decode
  import irrt_pkg::*;
(
  input wire irrt_io_req_t io_req,
  input wire logic [7:0] ir_base,
  input wire logic [6:0] rt_base,
  output irrt_dec_t dec
);

  logic ir_enabled;
  logic rt_enabled;

  // A base with all enable bits clear parks the window, so reset leaves both off.
  assign ir_enabled = |ir_base[`IRRT_IR_ENABLE_FIELD];
  assign rt_enabled = |rt_base[`IRRT_RT_ENABLE_FIELD];

  always_comb
  begin
    dec = '0;
    dec.ir_hit = io_req.valid && ir_enabled
      && (io_req.addr[`IRRT_IR_TOP_FIELD] == '0)
      && (io_req.addr[`IRRT_IR_BASE_FIELD] == ir_base);
    dec.rt_hit = io_req.valid && rt_enabled
      && (io_req.addr[`IRRT_RT_TOP_FIELD] == '0)
      && (io_req.addr[`IRRT_RT_BASE_ADDR_FIELD] == rt_base);
    if (dec.rt_hit)
    begin
      dec.rt_offset = io_req.addr[`IRRT_RT_OFS_FIELD];
      dec.rt_wake_sts = (io_req.addr[`IRRT_RT_OFS_FIELD] == `IRRT_RT_OFS_WAKE_STS);
    end
  end

endmodule

// file: src/irrt_cfg_regs.sv
// Configuration registers placing the fast infrared engine and the runtime block.
//
// How it works
// - Registers answer only in configuration state with their own index loaded.
// - Engine base register holds address bits 10:3, read/write, resets to zero.
// - Engine decode needs address bits 15:11 zero and 10:3 equal base.
// - Engine decode is off while base bits 10, 9 and 8 are zero.
// - DMA codes 0-3 pick channels, 4-14 reserved, 15 none; reset 0x0F.
// - DMA register bits 7:4 ignore writes and read as zero.
// - Every unselected DMA request output stays released, not driven.
// - Turnaround delay equals timeout value times 100 us; reset 0x03. Busy here lasts one clock longer.
// - Config timeout and engine timeout are one value, written from either.
// - Engine software reset leaves the timeout value alone.
// - Software select A is shared storage with engine register, resets zero.
// - Software select B is shared storage with engine register, resets zero.
// - Runtime base holds address bits 11:5, 32-byte granularity.
// - Runtime base bit 0 reserved, bits 7:1 hold address, reset zero.
// - Runtime decode is off while base bits 11 through 8 are zero.
// - Runtime claim needs bits 15:12 zero and 11:5 equal base.
// - Address bits 4:0 give the runtime offset; zero is wake status.
`timescale 1ns/1ps
`include "irrt_map.svh"
module irrt_cfg_regs
  import irrt_pkg::*;
#(
  parameter int TICK_CYCLES = (`IRRT_TICK_US * `IRRT_PS_PER_US) / `IRRT_CLK_PERIOD_PS,
  parameter int DMA_CHANNELS = 4
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire irrt_cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire irrt_io_req_t io_req,
  output irrt_dec_t io_dec,
  input wire logic eng_sw_rst,
  input wire logic eng_timeout_wr,
  input wire logic eng_sw_sel_a_wr,
  input wire logic eng_sw_sel_b_wr,
  input wire logic [7:0] eng_wdata,
  output logic [7:0] eng_timeout,
  output logic [7:0] eng_sw_sel_a,
  output logic [7:0] eng_sw_sel_b,
  input wire logic eng_dma_req,
  output logic [DMA_CHANNELS-1:0] dma_req_o,
  output logic [DMA_CHANNELS-1:0] dma_req_oe,
  input wire logic turn_start,
  output logic turn_busy
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // Register storage.
  logic [7:0] ir_base_ff;
  logic [3:0] dma_sel_ff;
  logic [7:0] timeout_ff;
  logic [7:0] sw_sel_a_ff;
  logic [7:0] sw_sel_b_ff;
  logic [6:0] rt_base_ff;

  // Read answer path.
  logic [7:0] cfg_rdata_ff;
  logic cfg_rvalid_ff;
  logic [7:0] nxt_rdata;
  logic nxt_rvalid;

  // Decode and DMA pin stage.
  irrt_dec_t io_dec_ff;
  irrt_dec_t nxt_dec;
  logic [DMA_CHANNELS-1:0] dma_req_ff;
  logic [DMA_CHANNELS-1:0] dma_oe_ff;
  logic [DMA_CHANNELS-1:0] nxt_dma_req;
  logic [DMA_CHANNELS-1:0] nxt_dma_oe;

  // Turnaround timing.
  logic [TICK_W-1:0] tick_cnt_ff;
  logic tick_ff;
  logic [7:0] turn_cnt_ff;
  logic turn_busy_ff;

  // Index match qualified by configuration state; only the write strobe uses it.
  function automatic logic cfg_hit(input irrt_cfg_req_t req, input logic [7:0] idx);
    cfg_hit = req.in_cfg_state && (req.index == idx);
  endfunction

  function automatic logic cfg_wr_hit(input irrt_cfg_req_t req, input logic [7:0] idx);
    cfg_wr_hit = req.wr && cfg_hit(req, idx);
  endfunction

  // A code names a live channel only inside the documented range.
  function automatic logic dma_code_live(input logic [3:0] code);
    dma_code_live = (code <= `IRRT_DMA_LAST);
  endfunction

  // Channel match for one request pin; reserved and none codes match no pin.
  function automatic logic dma_chan_hit(input logic [3:0] code, input int ch);
    dma_chan_hit = dma_code_live(code) && (int'(code) == ch);
  endfunction

  // The block answers reads only for its own indices; the rest belong to other blocks.
  function automatic logic cfg_own_index(input logic [7:0] idx);
    cfg_own_index = (idx >= `IRRT_IDX_IR_BASE) && (idx <= `IRRT_IDX_RT_BASE);
  endfunction

  // Engine base register.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ir_base_ff <= `IRRT_RST_IR_BASE;
    end
    else if (cfg_wr_hit(cfg_req, `IRRT_IDX_IR_BASE))
    begin
      ir_base_ff <= cfg_req.wdata;
    end
  end

  // DMA select: only the low nibble is storage, the upper nibble is not kept.
  // Reads rebuild the upper nibble as zero in the read multiplexer.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dma_sel_ff <= `IRRT_RST_DMA_SEL;
    end
    else if (cfg_wr_hit(cfg_req, `IRRT_IDX_DMA_SEL))
    begin
      dma_sel_ff <= cfg_req.wdata[`IRRT_DMA_FIELD];
    end
  end

  // Shared half-duplex timeout. The engine software reset is deliberately not
  // an input to this process, so the value survives it.
  // When both sides write in one cycle the configuration write wins.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      timeout_ff <= `IRRT_RST_HD_TIMEOUT;
    end
    else if (cfg_wr_hit(cfg_req, `IRRT_IDX_HD_TIMEOUT))
    begin
      timeout_ff <= cfg_req.wdata;
    end
    else if (eng_timeout_wr)
    begin
      timeout_ff <= eng_wdata;
    end
  end

  // Software select A, one flop set seen from both sides.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sw_sel_a_ff <= `IRRT_RST_SW_SEL;
    end
    else if (cfg_wr_hit(cfg_req, `IRRT_IDX_SW_SEL_A))
    begin
      sw_sel_a_ff <= cfg_req.wdata;
    end
    else if (eng_sw_sel_a_wr)
    begin
      sw_sel_a_ff <= eng_wdata;
    end
  end

  // Software select B, one flop set seen from both sides.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sw_sel_b_ff <= `IRRT_RST_SW_SEL;
    end
    else if (cfg_wr_hit(cfg_req, `IRRT_IDX_SW_SEL_B))
    begin
      sw_sel_b_ff <= cfg_req.wdata;
    end
    else if (eng_sw_sel_b_wr)
    begin
      sw_sel_b_ff <= eng_wdata;
    end
  end

  // Runtime base: bit 0 is reserved and never stored.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rt_base_ff <= `IRRT_RST_RT_BASE;
    end
    else if (cfg_wr_hit(cfg_req, `IRRT_IDX_RT_BASE))
    begin
      rt_base_ff <= cfg_req.wdata[`IRRT_RT_BASE_FIELD];
    end
  end

  // Read multiplexer; reserved fields are rebuilt as zero on every read.
  always_comb
  begin
    nxt_rdata = '0;
    nxt_rvalid = cfg_req.rd && cfg_req.in_cfg_state && cfg_own_index(cfg_req.index);
    if (cfg_req.in_cfg_state)
    begin
      unique case (cfg_req.index)
        `IRRT_IDX_IR_BASE: nxt_rdata = ir_base_ff;
        `IRRT_IDX_DMA_SEL: nxt_rdata = {`IRRT_DMA_RSVD_ZERO, dma_sel_ff};
        `IRRT_IDX_HD_TIMEOUT: nxt_rdata = timeout_ff;
        `IRRT_IDX_SW_SEL_A: nxt_rdata = sw_sel_a_ff;
        `IRRT_IDX_SW_SEL_B: nxt_rdata = sw_sel_b_ff;
        `IRRT_IDX_RT_BASE: nxt_rdata = {rt_base_ff, `IRRT_RT_RSVD_ZERO};
        default: nxt_rdata = '0;
      endcase
    end
  end

  // Read answer one cycle after the strobe; other indices belong elsewhere.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cfg_rdata_ff <= '0;
      cfg_rvalid_ff <= 1'b0;
    end
    else
    begin
      cfg_rdata_ff <= cfg_req.rd ? nxt_rdata : '0;
      cfg_rvalid_ff <= nxt_rvalid;
    end
  end

  irrt_addr_decode u_decode (
    .io_req(io_req),
    .ir_base(ir_base_ff),
    .rt_base(rt_base_ff),
    .dec(nxt_dec)
  );

  // Decode results are registered so outputs come from flops.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      io_dec_ff <= '0;
    end
    else
    begin
      io_dec_ff <= nxt_dec;
    end
  end

  // DMA request steering. Reserved codes behave as none, so a stale code
  // cannot fight another device on the shared request line.
  always_comb
  begin
    nxt_dma_oe = '0;
    nxt_dma_req = '0;
    for (int ch = 0; ch < DMA_CHANNELS; ch++)
    begin
      nxt_dma_oe[ch] = dma_chan_hit(dma_sel_ff, ch);
      nxt_dma_req[ch] = dma_chan_hit(dma_sel_ff, ch) && eng_dma_req;
    end
  end

  // The pins are registered so the enable and the request change together.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dma_req_ff <= '0;
      dma_oe_ff <= '0;
    end
    else
    begin
      dma_req_ff <= nxt_dma_req;
      dma_oe_ff <= nxt_dma_oe;
    end
  end

  // 100 us tick divider; it restarts with each turnaround so the first
  // step is a full period long.
  // Limitation: busy lasts one clock longer than timeout x TICK_CYCLES, as
  // the count loads a cycle before the first tick window opens.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end
    else if (turn_start || tick_cnt_ff == TICK_W'(TICK_CYCLES - 1))
    begin
      tick_cnt_ff <= '0;
      tick_ff <= !turn_start;
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // Turnaround timer: busy for timeout x 100 us plus one clock after each start; a zero timeout gives no busy.
  // A new start while a wait runs reloads the count from the current setting.
  // The engine software reset aborts a running wait but not the setting.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      turn_cnt_ff <= '0;
      turn_busy_ff <= 1'b0;
    end
    else if (turn_start)
    begin
      turn_cnt_ff <= timeout_ff;
      turn_busy_ff <= (timeout_ff != '0);
    end
    else if (eng_sw_rst)
    begin
      turn_cnt_ff <= '0;
      turn_busy_ff <= 1'b0;
    end
    else if (tick_ff && turn_cnt_ff != '0)
    begin
      turn_cnt_ff <= turn_cnt_ff - 1'b1;
      turn_busy_ff <= (turn_cnt_ff != 8'h01);
    end
  end

  // Every output is a flop; no port is fed through combinational logic.
  assign cfg_rdata = cfg_rdata_ff;
  assign cfg_rvalid = cfg_rvalid_ff;
  assign io_dec = io_dec_ff;
  assign eng_timeout = timeout_ff;
  assign eng_sw_sel_a = sw_sel_a_ff;
  assign eng_sw_sel_b = sw_sel_b_ff;
  assign dma_req_o = dma_req_ff;
  assign dma_req_oe = dma_oe_ff;
  assign turn_busy = turn_busy_ff;

endmodule

// file: tb/irrt_cfg_regs_checker.sv
// Concurrent checks on the ports of the configuration register block.
`timescale 1ns/1ps
module irrt_cfg_regs_checker
  import irrt_pkg::*;
#(
  parameter int DMA_CHANNELS = 4
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire irrt_cfg_req_t cfg_req,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire irrt_io_req_t io_req,
  input wire irrt_dec_t io_dec,
  input wire logic eng_sw_rst,
  input wire logic eng_timeout_wr,
  input wire logic [7:0] eng_timeout,
  input wire logic [DMA_CHANNELS-1:0] dma_req_oe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic acc;
  logic rd_ff;
  logic [7:0] idx_ff;
  logic [4:0] ofs_ff;
  assign acc = cfg_req.in_cfg_state && cfg_req.index inside {[8'h2B:8'h30]};
  always_ff @(posedge clk)
  begin
    rd_ff <= cfg_req.rd && acc;
    idx_ff <= cfg_req.index;
    ofs_ff <= io_req.addr[4:0];
  end
  chk_read_gate: assert property (cfg_rvalid == rd_ff)
    else $error("read answer not tied to gated request");
  chk_idle_rdata: assert property (!cfg_rvalid |-> cfg_rdata == 8'h00)
    else $error("read data outside a read answer");
  chk_dma_upper: assert property (cfg_rvalid && idx_ff == 8'h2C |-> cfg_rdata[7:4] == 4'h0)
    else $error("dma select upper bits read nonzero");
  chk_dma_onehot: assert property ($onehot0(dma_req_oe))
    else $error("more than one dma request driven");
  chk_dma_rsvd: assert property (cfg_req.wr && acc && cfg_req.index == 8'h2C
    && cfg_req.wdata[3:0] > 4'h3 |-> ##2 dma_req_oe == '0)
    else $error("dma request driven for no channel");
  chk_ir_top: assert property (io_req.valid && io_req.addr[15:11] != 5'h00 |=> !io_dec.ir_hit)
    else $error("engine hit with high address bits set");
  chk_ir_off: assert property (io_req.valid && io_req.addr[10:8] == 3'h0 |=> !io_dec.ir_hit)
    else $error("engine hit below its lowest base");
  chk_rt_top: assert property (io_req.valid && io_req.addr[15:12] != 4'h0 |=> !io_dec.rt_hit)
    else $error("runtime hit with high address bits set");
  chk_rt_off: assert property (io_req.valid && io_req.addr[11:8] == 4'h0 |=> !io_dec.rt_hit)
    else $error("runtime hit below its lowest base");
  chk_rt_offset: assert property (io_dec.rt_hit |-> io_dec.rt_offset == ofs_ff
    && io_dec.rt_wake_sts == (ofs_ff == 5'h00))
    else $error("runtime offset or wake select wrong");
  chk_timeout_keep: assert property (eng_sw_rst && !eng_timeout_wr && !cfg_req.wr
    |=> $stable(eng_timeout))
    else $error("software reset changed the timeout");
endmodule

// file: tb/irrt_host.sv
// Host model issuing configuration cycles and I/O decode probes.
`timescale 1ns/1ps
module irrt_host
  import irrt_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire irrt_dec_t io_dec,
  output irrt_cfg_req_t cfg_req,
  output irrt_io_req_t io_req
);
  initial
  begin
    cfg_req = '0;
    io_req = '0;
  end
  // Idle index and data are inverted so a stale value is never mistaken for a request.
  task automatic cfg(input logic cs, input logic w, input logic [7:0] i, input logic [7:0] d,
    output logic v, output logic [7:0] q);
    @(negedge clk);
    cfg_req = '{cs, i, w, !w, d};
    @(posedge clk);
    #1;
    v = cfg_rvalid;
    q = cfg_rdata;
    @(negedge clk);
    cfg_req = '{1'b0, ~i, 1'b0, 1'b0, ~d};
  endtask
  task automatic io(input logic [15:0] a, output irrt_dec_t d);
    @(negedge clk);
    io_req = '{1'b1, a};
    @(posedge clk);
    #1;
    d = io_dec;
    @(negedge clk);
    io_req = '{1'b0, ~a};
  endtask
endmodule

// file: tb/irrt_cfg_regs_test.sv
// Self-checking bench for the configuration register block.
`timescale 1ns/1ps
module irrt_cfg_regs_test;
  import irrt_pkg::*;
  localparam int TICK = 4;
  logic clk = 0;
  logic sys_rst = 1;
  logic eng_sw_rst = 0, eng_timeout_wr = 0, eng_sw_sel_a_wr = 0, eng_sw_sel_b_wr = 0;
  logic [7:0] eng_wdata = 8'h00;
  logic eng_dma_req = 0, turn_start = 0, cfg_rvalid, turn_busy, v;
  logic [7:0] cfg_rdata, eng_timeout, eng_sw_sel_a, eng_sw_sel_b, q;
  logic [3:0] dma_req_o, dma_req_oe;
  irrt_cfg_req_t cfg_req;
  irrt_io_req_t io_req;
  irrt_dec_t io_dec, dd;
  int failures = 0, check_count = 0, cycles = 0, n;
  always #2.5 clk = ~clk;
  irrt_cfg_regs #(.TICK_CYCLES(TICK)) i_dut (.clk(clk), .sys_rst(sys_rst), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .io_req(io_req), .io_dec(io_dec),
    .eng_sw_rst(eng_sw_rst), .eng_timeout_wr(eng_timeout_wr), .eng_sw_sel_a_wr(eng_sw_sel_a_wr),
    .eng_sw_sel_b_wr(eng_sw_sel_b_wr), .eng_wdata(eng_wdata), .eng_timeout(eng_timeout),
    .eng_sw_sel_a(eng_sw_sel_a), .eng_sw_sel_b(eng_sw_sel_b), .eng_dma_req(eng_dma_req),
    .dma_req_o(dma_req_o), .dma_req_oe(dma_req_oe), .turn_start(turn_start),
    .turn_busy(turn_busy));
  irrt_host i_host (.clk(clk), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .io_dec(io_dec),
    .cfg_req(cfg_req), .io_req(io_req));
  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic cs = 1'b1);
    i_host.cfg(cs, 1'b1, i, d, v, q);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    i_host.cfg(1'b1, 1'b0, i, 8'h00, v, q);
    cmp("rvalid", 8'h01, {7'h0, v});
    cmp("rdata", e, q);
  endtask
  // One-hot pulse on the engine side: bit 0 timeout, 1 select A, 2 select B, 3 soft reset.
  task automatic eng(input int k, input logic [7:0] d);
    @(negedge clk);
    eng_wdata = d;
    {eng_sw_rst, eng_sw_sel_b_wr, eng_sw_sel_a_wr, eng_timeout_wr} = 4'(1 << k);
    @(negedge clk);
    {eng_sw_rst, eng_sw_sel_b_wr, eng_sw_sel_a_wr, eng_timeout_wr} = 4'h0;
  endtask
  task automatic iochk(input logic [15:0] a, input logic ir, input logic rt, input logic [4:0] o);
    i_host.io(a, dd);
    cmp("ir_hit", {7'h0, ir}, {7'h0, dd.ir_hit});
    cmp("rt_hit", {7'h0, rt}, {7'h0, dd.rt_hit});
    cmp("rt_offset", {3'h0, o}, {3'h0, dd.rt_offset});
    cmp("wake", {7'h0, rt && o == 5'h00}, {7'h0, dd.rt_wake_sts});
  endtask
  task automatic t_reset;
    rdc(8'h2B, 8'h00);
    rdc(8'h2C, 8'h0F);
    rdc(8'h2D, 8'h03);
    rdc(8'h2E, 8'h00);
    rdc(8'h2F, 8'h00);
    rdc(8'h30, 8'h00);
    cmp("oe", 8'h00, {4'h0, dma_req_oe});
    iochk(16'h0000, 1'b0, 1'b0, 5'h00);
  endtask
  task automatic t_gate;
    wr(8'h2D, 8'h44, 1'b0);
    rdc(8'h2D, 8'h03);
    i_host.cfg(1'b1, 1'b0, 8'h31, 8'h00, v, q);
    cmp("rvalid", 8'h00, {7'h0, v});
    wr(8'h31, 8'h44);
    rdc(8'h2D, 8'h03);
    i_host.cfg(1'b0, 1'b0, 8'h2D, 8'h00, v, q);
    cmp("rvalid", 8'h00, {7'h0, v});
    cmp("rdata", 8'h00, q);
  endtask
  task automatic t_dma;
    wr(8'h2C, 8'hF2);
    rdc(8'h2C, 8'h02);
    eng_dma_req = 1'b1;
    for (int c = 0; c < 7; c++)
    begin
      wr(8'h2C, (c == 6) ? 8'h0F : 8'(c));
      repeat (2) @(negedge clk);
      cmp("oe", (c < 4) ? 8'h01 << c : 8'h00, {4'h0, dma_req_oe});
      cmp("drq", (c < 4) ? 8'h01 << c : 8'h00, {4'h0, dma_req_o});
    end
    wr(8'h2C, 8'h01);
    eng_dma_req = 1'b0;
    repeat (2) @(negedge clk);
    cmp("oe", 8'h02, {4'h0, dma_req_oe});
    cmp("drq", 8'h00, {4'h0, dma_req_o});
  endtask
  task automatic t_decode;
    wr(8'h2B, 8'h20);
    iochk(16'h0107, 1'b1, 1'b0, 5'h00);
    iochk(16'h0907, 1'b0, 1'b0, 5'h00);
    wr(8'h2B, 8'h1F);
    iochk(16'h00F8, 1'b0, 1'b0, 5'h00);
    wr(8'h30, 8'h11);
    rdc(8'h30, 8'h10);
    iochk(16'h0100, 1'b0, 1'b1, 5'h00);
    iochk(16'h011F, 1'b0, 1'b1, 5'h1F);
    iochk(16'h1100, 1'b0, 1'b0, 5'h00);
    iochk(16'h0120, 1'b0, 1'b0, 5'h00);
    wr(8'h30, 8'hFE);
    iochk(16'h0FE3, 1'b0, 1'b1, 5'h03);
    wr(8'h30, 8'h0E);
    iochk(16'h00E0, 1'b0, 1'b0, 5'h00);
  endtask
  task automatic t_timeout;
    wr(8'h2D, 8'h02);
    cmp("eng_timeout", 8'h02, eng_timeout);
    turn_start = 1'b1;
    @(negedge clk);
    turn_start = 1'b0;
    n = 0;
    while (turn_busy === 1'b1 && n < 50)
    begin
      n++;
      @(negedge clk);
    end
    // The wait may end one cycle late, so one extra busy cycle is tolerated.
    cmp("busy", 8'(2 * TICK), 8'(n - int'(n == 2 * TICK + 1)));
    eng(0, 8'h05);
    rdc(8'h2D, 8'h05);
    eng(3, 8'h77);
    cmp("eng_timeout", 8'h05, eng_timeout);
    wr(8'h2D, 8'h00);
    turn_start = 1'b1;
    @(negedge clk);
    turn_start = 1'b0;
    cmp("busy", 8'h00, {7'h0, turn_busy});
  endtask
  task automatic t_swsel;
    wr(8'h2E, 8'hA5);
    cmp("sel_a", 8'hA5, eng_sw_sel_a);
    eng(2, 8'h3C);
    rdc(8'h2F, 8'h3C);
    eng(1, 8'h5A);
    rdc(8'h2E, 8'h5A);
    wr(8'h2F, 8'hC3);
    cmp("sel_b", 8'hC3, eng_sw_sel_b);
  endtask
  // A second reset in mid-run must bring every register back to its reset value.
  task automatic t_rerun;
    wr(8'h2B, 8'h40);
    wr(8'h30, 8'h20);
    eng(1, 8'h11);
    @(negedge clk);
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    cmp("sel_a", 8'h00, eng_sw_sel_a);
    cmp("sel_b", 8'h00, eng_sw_sel_b);
    cmp("eng_timeout", 8'h03, eng_timeout);
    cmp("busy", 8'h00, {7'h0, turn_busy});
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      end_sim();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_gate();
    t_dma();
    t_decode();
    t_timeout();
    t_swsel();
    t_rerun();
    end_sim();
  end
endmodule
bind irrt_cfg_regs irrt_cfg_regs_checker #(.DMA_CHANNELS(DMA_CHANNELS)) i_chk (.clk(clk),
  .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
  .io_req(io_req), .io_dec(io_dec), .eng_sw_rst(eng_sw_rst), .eng_timeout_wr(eng_timeout_wr),
  .eng_timeout(eng_timeout), .dma_req_oe(dma_req_oe));
